/* File: core/rpa_pkg.sv */
// Notes on behaviour
// R1: second green palette level is 8 bits, resets to 0x60, 125 uA per code.
// R2: second green writes above 0xC0 clamp to 0xC0 and read back as 0xC0.
// R3: second blue palette level is 8 bits, resets to 0x60, 125 uA per code.
// R4: second blue writes 0xC1 through 0xFF clamp to 0xC0 on readback.
// R5: low-pair bit 7 enables module A1; cleared means fade to zero and hold.
// R6: module A1 bits 6,5,4 pick red on A3, green on A2, blue on A4.
// R7: low-pair bit 3 enables module A2; zero means fade to zero current.
// R8: module A2 bits 2,1,0 pick red on A4, green on A3, blue on A1.
// R9: high-pair bit 7 enables module A3; cleared means fade to zero and hold.
// R10: module A3 bits 6,5,4 pick red on A1, green on A4, blue on A2.
// R11: high-pair bit 3 enables module A4; zero means fade to zero current.
// R12: module A4 bits 2,1,0 pick red on A2, green on A1, blue on A3; reset zero.
// R13: first entries and second red use same coding; reset 0x28 and 0x60.
// R14: enable or select changes reach the lines only through fade engines.
// R15: while a module's anode phase is active, its three faded levels drive other lines.
package rpa_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RED_ZERO   = 8'h03;
  localparam logic [7:0] REG_GREEN_ZERO = 8'h04;
  localparam logic [7:0] REG_BLUE_ZERO  = 8'h05;
  localparam logic [7:0] REG_RED_ONE    = 8'h06;
  localparam logic [7:0] REG_GREEN_TWO  = 8'h07; // green_level_second
  localparam logic [7:0] REG_BLUE_TWO   = 8'h08; // blue_level_second
  localparam logic [7:0] REG_SEL_LOW    = 8'h09; // group_a_select_low_pair
  localparam logic [7:0] REG_SEL_HIGH   = 8'h0A; // group_a_select_high_pair

  // ----------------------------------------------------------------------
  // reset values and level coding
  // ----------------------------------------------------------------------
  localparam logic [7:0] LEVEL_ZERO_RST = 8'h28;
  localparam logic [7:0] LEVEL_ONE_RST  = 8'h60;
  localparam logic [7:0] LEVEL_MAX      = 8'hC0;
  localparam logic [7:0] SEL_RST        = 8'h00;
  localparam int         NUM_LEVELS     = 6;
  localparam int         NUM_MODULES    = 4;
  localparam int         NUM_COLOURS    = 3;

  // ----------------------------------------------------------------------
  // select register fields, per module within a pair
  // ----------------------------------------------------------------------
  localparam int EN_HI_POS  = 7;
  localparam int SEL_HI_LSB = 4;
  localparam int EN_LO_POS  = 3;
  localparam int SEL_LO_LSB = 0;

  // colour order within a pick field: bit 2 red, bit 1 green, bit 0 blue
  localparam int COL_RED   = 0;
  localparam int COL_GREEN = 1;
  localparam int COL_BLUE  = 2;

  // cathode line offset from a module's anchor line, modulo four
  localparam int LINE_OFS_RED   = 2;
  localparam int LINE_OFS_GREEN = 1;
  localparam int LINE_OFS_BLUE  = 3;
  // entry-one levels sit this many slots above entry zero
  localparam int BANK_ONE_OFS   = 3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS             = 25;
  localparam int MUX_PHASE_NS       = 10000;
  localparam int MUX_PHASE_CYCLES   = MUX_PHASE_NS / CLK_NS;
  localparam int FADE_STEP_NS       = 100000;
  localparam int FADE_STEP_CYCLES   = FADE_STEP_NS / CLK_NS;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } rpa_reg_req_s;

  typedef struct packed {
    logic [3:0]      anodeOn;
    logic [3:0][7:0] lineLevel;
  } rpa_drive_s;

endpackage : rpa_pkg

/* File: core/rpa_fade_ramp.sv */
`timescale 1ns/1ps
// one linear fade engine: walks its level one code per step toward target
module rpa_fade_ramp #(
  parameter int STEP_CYCLES = rpa_pkg::FADE_STEP_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // target and present level
  input  wire logic [7:0] target,
  output logic      [7:0] level
);

  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

  typedef struct packed {
    logic [7:0]    level;
    logic [CW-1:0] cnt;
  } rpa_fade_s;

  rpa_fade_s state_r;
  rpa_fade_s state_nxt;

  // ----------------------------------------------------------------------
  // step timer and ramp
  // ----------------------------------------------------------------------
  // starting from zero, so nothing lights before software enables it
  always_comb
  begin
    state_nxt = state_r;
    if (state_r.cnt == STEP_LAST)
    begin
      state_nxt.cnt = '0;
      if (state_r.level < target)
        state_nxt.level = state_r.level + 8'h01;
      else if (state_r.level > target)
        state_nxt.level = state_r.level - 8'h01;
    end
    else
      state_nxt.cnt = state_r.cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign level = state_r.level;

endmodule : rpa_fade_ramp

/* File: core/rpa_select_bank.sv */
`timescale 1ns/1ps
// palette and group-A selection registers, fades and multiplex drive
module rpa_select_bank #(
  parameter int PHASE_CYCLES = rpa_pkg::MUX_PHASE_CYCLES,
  parameter int STEP_CYCLES  = rpa_pkg::FADE_STEP_CYCLES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port from the serial interface logic
  input  wire rpa_pkg::rpa_reg_req_s regReq,
  output logic               [7:0]  regRdData,
  // multiplexed line drive
  output rpa_pkg::rpa_drive_s       drive
);

  localparam int PW = $clog2(PHASE_CYCLES + 1);
  localparam logic [PW-1:0] PHASE_LAST = PW'(PHASE_CYCLES - 1);

  // one phase per anchor line; the enum keeps illegal phase values out of
  // the case decoders below, which still fall back to the first phase or, in anodeOf, to no anode
  typedef enum logic [1:0] {PHASE_A1, PHASE_A2, PHASE_A3, PHASE_A4} rpa_phase_e;

  typedef struct packed {
    logic [rpa_pkg::NUM_LEVELS-1:0][7:0] levels;
    logic [7:0]                          selLow;
    logic [7:0]                          selHigh;
    logic [PW-1:0]                       phaseCnt;
    rpa_phase_e                          phase;
    logic [7:0]                          rdData;
    rpa_pkg::rpa_drive_s                 drive;
  } rpa_bank_s;

  rpa_bank_s state_r;
  rpa_bank_s state_nxt;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // codes above full scale store as full scale, so readback shows the clamp
  function automatic logic [7:0] clampLevel(input logic [7:0] code);
    clampLevel = (code > rpa_pkg::LEVEL_MAX) ? rpa_pkg::LEVEL_MAX : code; // R2 R4
  endfunction : clampLevel

  // true for addresses that hold a palette level
  function automatic logic isLevelAddr(input logic [7:0] addr);
    isLevelAddr = (addr >= rpa_pkg::REG_RED_ZERO) && (addr <= rpa_pkg::REG_BLUE_TWO);
  endfunction : isLevelAddr

  // palette slot of a level address: entry zero red, green, blue, then
  // entry one; other addresses never get here, isLevelAddr guards them
  function automatic int levelSlot(input logic [7:0] addr);
    case (addr)
      rpa_pkg::REG_RED_ZERO:   levelSlot = rpa_pkg::COL_RED;
      rpa_pkg::REG_GREEN_ZERO: levelSlot = rpa_pkg::COL_GREEN;
      rpa_pkg::REG_BLUE_ZERO:  levelSlot = rpa_pkg::COL_BLUE;
      rpa_pkg::REG_RED_ONE:    levelSlot = rpa_pkg::COL_RED + rpa_pkg::BANK_ONE_OFS;
      rpa_pkg::REG_GREEN_TWO:  levelSlot = rpa_pkg::COL_GREEN + rpa_pkg::BANK_ONE_OFS;
      rpa_pkg::REG_BLUE_TWO:   levelSlot = rpa_pkg::COL_BLUE + rpa_pkg::BANK_ONE_OFS;
      default:                 levelSlot = rpa_pkg::COL_RED;
    endcase
  endfunction : levelSlot

  // cathode line of one colour of the module anchored on line k; the
  // rotation follows the board wiring, so every anchor uses the same offsets
  function automatic int lineOf(input int k, input int colour);
    int ofs;
    case (colour)
      rpa_pkg::COL_RED:   ofs = rpa_pkg::LINE_OFS_RED;
      rpa_pkg::COL_GREEN: ofs = rpa_pkg::LINE_OFS_GREEN;
      default:            ofs = rpa_pkg::LINE_OFS_BLUE;
    endcase
    lineOf = (k + ofs) % rpa_pkg::NUM_MODULES;
  endfunction : lineOf

  // anchor lines take their turn A1, A2, A3, A4, then wrap
  function automatic rpa_phase_e nextPhase(input rpa_phase_e ph);
    case (ph)
      PHASE_A1: nextPhase = PHASE_A2;
      PHASE_A2: nextPhase = PHASE_A3;
      PHASE_A3: nextPhase = PHASE_A4;
      PHASE_A4: nextPhase = PHASE_A1;
      default:  nextPhase = PHASE_A1;
    endcase
  endfunction : nextPhase

  // one-hot anode select of a phase
  function automatic logic [3:0] anodeOf(input rpa_phase_e ph);
    case (ph)
      PHASE_A1: anodeOf = 4'h1;
      PHASE_A2: anodeOf = 4'h2;
      PHASE_A3: anodeOf = 4'h4;
      PHASE_A4: anodeOf = 4'h8;
      default:  anodeOf = 4'h0;
    endcase
  endfunction : anodeOf

  // pick field and enable of module k, taken from its pair register
  function automatic logic [3:0] moduleField(input logic [7:0] lo, input logic [7:0] hi,
                                             input int k);
    logic [7:0] r;
    r = (k < 2) ? lo : hi;
    if ((k % 2) == 0)
      moduleField = {r[rpa_pkg::EN_HI_POS], r[rpa_pkg::SEL_HI_LSB +: 3]};
    else
      moduleField = {r[rpa_pkg::EN_LO_POS], r[rpa_pkg::SEL_LO_LSB +: 3]};
  endfunction : moduleField

  // ----------------------------------------------------------------------
  // target per module and colour, then the fade engines
  // ----------------------------------------------------------------------
  logic [rpa_pkg::NUM_MODULES-1:0][rpa_pkg::NUM_COLOURS-1:0][7:0] target;
  logic [rpa_pkg::NUM_MODULES-1:0][rpa_pkg::NUM_COLOURS-1:0][7:0] faded;

  genvar gk, gc;
  generate
    for (gk = 0; gk < rpa_pkg::NUM_MODULES; gk++)
    begin : g_module
      logic [3:0] field;
      assign field = moduleField(state_r.selLow, state_r.selHigh, gk); // R5 R7 R9 R11
      for (gc = 0; gc < rpa_pkg::NUM_COLOURS; gc++)
      begin : g_colour
        // pick bit 2 is red, 1 green, 0 blue; bank 1 sits three slots up
        logic pick;
        assign pick = field[2 - gc]; // R6 R8 R10 R12
        // disabled module heads for zero, the ramp takes it there
        assign target[gk][gc] = field[3]
                                ? state_r.levels[gc + (pick ? rpa_pkg::BANK_ONE_OFS : 0)]
                                : 8'h00; // R5 R7 R9 R11
        // every target change goes through a ramp, never a step
        rpa_fade_ramp #(
          .STEP_CYCLES (STEP_CYCLES)
        ) u_fade (
          .clk    (clk),
          .rst    (rst),
          .target (target[gk][gc]),
          .level  (faded[gk][gc])
        ); // R14
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next state: register writes, readback, phase timer, line drive
  // ----------------------------------------------------------------------
  // line of colour c for the module anchored on line k: red k+2, green
  // k+1, blue k+3, all modulo four, which matches each anode's wiring
  always_comb
  begin
    int idx;
    int ln;
    idx = 0;
    ln = 0;
    state_nxt = state_r;

    // writes; unmapped addresses are ignored
    // a read of the address being written returns the old value this cycle
    if (regReq.wrEn)
    begin
      if (isLevelAddr(regReq.addr))
      begin
        idx = levelSlot(regReq.addr);
        state_nxt.levels[idx] = clampLevel(regReq.wrData); // R1 R2 R3 R4 R13
      end
      else if (regReq.addr == rpa_pkg::REG_SEL_LOW)
        state_nxt.selLow = regReq.wrData;
      else if (regReq.addr == rpa_pkg::REG_SEL_HIGH)
        state_nxt.selHigh = regReq.wrData;
    end

    // readback of the stored, already clamped value; others read zero
    if (isLevelAddr(regReq.addr))
      state_nxt.rdData = state_r.levels[levelSlot(regReq.addr)];
    else if (regReq.addr == rpa_pkg::REG_SEL_LOW)
      state_nxt.rdData = state_r.selLow;
    else if (regReq.addr == rpa_pkg::REG_SEL_HIGH)
      state_nxt.rdData = state_r.selHigh;
    else
      state_nxt.rdData = 8'h00;

    // anode phase timer, one phase per anchor line in turn
    // phase time is a parameter; only the order A1..A4 is fixed
    if (state_r.phaseCnt == PHASE_LAST)
    begin
      state_nxt.phaseCnt = '0;
      state_nxt.phase = nextPhase(state_r.phase);
    end
    else
      state_nxt.phaseCnt = state_r.phaseCnt + 1'b1;

    // drive registered so lines and anode switch together; the anode's own
    // line stays at zero, it carries no cathode current
    state_nxt.drive.anodeOn = anodeOf(state_r.phase); // R15
    state_nxt.drive.lineLevel = '0;
    for (int c = 0; c < rpa_pkg::NUM_COLOURS; c++)
    begin
      ln = lineOf(int'(state_r.phase), c); // R6 R8 R10 R12
      state_nxt.drive.lineLevel[ln] = faded[state_r.phase][c]; // R15
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // levels and selects take their power-on values; fades restart at zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r          <= '0;
      state_r.levels   <= {rpa_pkg::LEVEL_ONE_RST, rpa_pkg::LEVEL_ONE_RST,
                           rpa_pkg::LEVEL_ONE_RST, rpa_pkg::LEVEL_ZERO_RST,
                           rpa_pkg::LEVEL_ZERO_RST, rpa_pkg::LEVEL_ZERO_RST}; // R1 R3 R13
      state_r.selLow   <= rpa_pkg::SEL_RST; // R12
      state_r.selHigh  <= rpa_pkg::SEL_RST; // R12
    end
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // both outputs come straight from flops, so the sinks never see a glitch
  assign regRdData = state_r.rdData;
  assign drive     = state_r.drive;

endmodule : rpa_select_bank

/* File: tb/rpa_select_bank_asserts.sv */
`timescale 1ns/1ps
// port-level checks on the palette bank
module rpa_select_bank_asserts #(
  parameter int PHASE_CYCLES = 4,
  parameter int STEP_CYCLES  = 2
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire rpa_pkg::rpa_reg_req_s regReq,
  input wire logic            [7:0] regRdData,
  input wire rpa_pkg::rpa_drive_s   drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // outputs quiet out of reset, first phase one edge later
  a_rst_quiet: assert property ($fell(rst) |-> (drive == '0 && regRdData == 8'h00) ##1
    (drive.anodeOn == 4'h1)) else $error("outputs not quiet after reset");
  a_unmapped_zero: assert property ((regReq.addr < 8'h03 || regReq.addr > 8'h0A)
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  // clamped writes read back at full scale
  a_green_clamp: assert property ((regReq.wrEn && regReq.addr == 8'h07 &&
    regReq.wrData > 8'hC0) ##1 (!regReq.wrEn && regReq.addr == 8'h07)
    |=> regRdData == 8'hC0) else $error("green second not clamped");
  a_blue_clamp: assert property ((regReq.wrEn && regReq.addr == 8'h08 &&
    regReq.wrData > 8'hC0) ##1 (!regReq.wrEn && regReq.addr == 8'h08)
    |=> regRdData == 8'hC0) else $error("blue second not clamped");
  // phase order and length
  a_order_two: assert property ($rose(drive.anodeOn[1]) |-> $past(drive.anodeOn) == 4'h1)
    else $error("A2 phase not after A1");
  a_order_wrap: assert property (($rose(drive.anodeOn[0]) && $past(drive.anodeOn) != 4'h0)
    |-> $past(drive.anodeOn) == 4'h8) else $error("A1 phase not after A4");
  // phase length counted in helper logic, so any PHASE_CYCLES works
  logic [3:0] prevAnode_r;
  int         phaseLen_r;
  always_ff @(posedge clk)
  begin
    prevAnode_r <= drive.anodeOn;
    if (rst || drive.anodeOn != prevAnode_r)
      phaseLen_r <= 0;
    else
      phaseLen_r <= phaseLen_r + 1;
  end
  a_phase_len: assert property ((drive.anodeOn != prevAnode_r && prevAnode_r != 4'h0)
    |-> phaseLen_r == PHASE_CYCLES - 1) else $error("phase length wrong");
  // anode line itself carries no cathode current
  a_anode_one_off: assert property (drive.anodeOn[0] |-> drive.lineLevel[0] == 8'h00)
    else $error("A1 line driven in its own phase");
  a_anode_four_off: assert property (drive.anodeOn[3] |-> drive.lineLevel[3] == 8'h00)
    else $error("A4 line driven in its own phase");
  // no abrupt steps: at most one code per cycle on line 1 within a phase
  a_fade_step: assert property (($stable(drive.anodeOn) && drive.anodeOn != 4'h0) |->
    (drive.lineLevel[1] - $past(drive.lineLevel[1])) inside {8'h00, 8'h01, 8'hFF})
    else $error("line level jumped");
endmodule : rpa_select_bank_asserts

bind rpa_select_bank rpa_select_bank_asserts #(.PHASE_CYCLES(PHASE_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) u_chk (.clk(clk), .rst(rst), .regReq(regReq),
  .regRdData(regRdData), .drive(drive));

/* File: tb/rpa_host_model.sv */
`timescale 1ns/1ps
// register host: single-byte writes and reads on the strobe port
module rpa_host_model (
  // clock
  input  wire logic                  clk,
  // register port
  output rpa_pkg::rpa_reg_req_s      regReq,
  input  wire logic            [7:0] regRdData
);
  initial regReq = '0;
  // released data is inverted so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regReq = '{wrEn: 1'b1, addr: a, wrData: d};
    @(posedge clk);
    #1 regReq = '{wrEn: 1'b0, addr: a, wrData: ~d};
  endtask : write_reg
  // answer is taken 1 ns after the edge that samples the address
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 regReq.addr = a;
    @(posedge clk);
    #1 d = regRdData;
  endtask : read_reg
endmodule : rpa_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} rpa_row_s;
  logic                  clk;
  logic                  rst;
  rpa_pkg::rpa_reg_req_s regReq;
  logic            [7:0] regRdData;
  rpa_pkg::rpa_drive_s   drive;
  int                    n_errors;
  int                    comparisons;
  logic            [7:0] rd;
  logic            [7:0] ex [4][4];
  // reset reads, clamp edges, selects, unmapped places
  rpa_row_s rows [15] = '{'{1'b0, 8'h07, 8'h00, 8'h60}, '{1'b0, 8'h08, 8'h00, 8'h60},
    '{1'b0, 8'h09, 8'h00, 8'h00}, '{1'b0, 8'h0A, 8'h00, 8'h00}, '{1'b0, 8'h03, 8'h00, 8'h28},
    '{1'b0, 8'h06, 8'h00, 8'h60}, '{1'b1, 8'h07, 8'hFF, 8'hC0}, '{1'b1, 8'h07, 8'hC1, 8'hC0},
    '{1'b1, 8'h07, 8'h12, 8'h12}, '{1'b1, 8'h08, 8'hC1, 8'hC0}, '{1'b1, 8'h08, 8'hC0, 8'hC0},
    '{1'b1, 8'h09, 8'hA5, 8'hA5}, '{1'b1, 8'h0A, 8'h5A, 8'h5A}, '{1'b1, 8'h0B, 8'h77, 8'h00},
    '{1'b1, 8'h02, 8'h33, 8'h00}};
  // palette, then A1 pick 101, A2 pick 010, A3 pick 011, A4 off
  logic [7:0] cfg [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'hDA, 8'hB0};

  rpa_select_bank #(.PHASE_CYCLES(4), .STEP_CYCLES(2)) u_rpa_select_bank (.clk(clk),
    .rst(rst), .regReq(regReq), .regRdData(regRdData), .drive(drive));
  rpa_host_model host (.clk(clk), .regReq(regReq), .regRdData(regRdData));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_byte

  // bounded wait for a phase, then every line against the table
  task automatic check_phases;
    int t;
    for (int k = 0; k < 4; k++)
    begin
      for (t = 0; t < 50 && drive.anodeOn !== 4'(1 << k); t++) @(posedge clk) #1;
      if (t == 50)
      begin
        n_errors++;
        $display("MISMATCH %0t phase never seen", $time);
      end
      else
        for (int l = 0; l < 4; l++) check_byte(drive.lineLevel[l], ex[k][l], "line");
    end
  endtask : check_phases

  initial
  begin
    n_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].wr) host.write_reg(rows[i].a, rows[i].d);
      host.read_reg(rows[i].a, rd);
      check_byte(rd, rows[i].e, "readback");
    end
    $display("test readback done");
    foreach (cfg[i]) host.write_reg(8'(i + 3), cfg[i]);
    repeat (9 * 2 + 8) @(posedge clk);
    #1 ex = '{'{8'h00, 8'h05, 8'h07, 8'h09}, '{8'h06, 8'h00, 8'h08, 8'h04},
      '{8'h04, 8'h09, 8'h00, 8'h08}, '{8'h00, 8'h00, 8'h00, 8'h00}};
    check_phases();
    $display("test palette picks done");
    // A1 and A3 off, A2 kept, A4 on with entry zero everywhere
    host.write_reg(8'h09, 8'h5A);
    host.write_reg(8'h0A, 8'h38);
    repeat (9 * 2 + 8) @(posedge clk);
    #1 ex[0] = '{8'h00, 8'h00, 8'h00, 8'h00};
    ex[2] = '{8'h00, 8'h00, 8'h00, 8'h00};
    ex[3] = '{8'h05, 8'h04, 8'h06, 8'h00};
    check_phases();
    $display("test disable done");
    // second reset mid-run
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    host.read_reg(8'h09, rd);
    check_byte(rd, 8'h00, "select after reset");
    host.read_reg(8'h07, rd);
    check_byte(rd, 8'h60, "green after reset");
    $display("test second reset done");
    finish_test();
  end
endmodule : testbench
